// File: design/bclc_pkg.sv
// Constants, field layouts and enumerations of the branch and loop control block
package bclc_pkg;

  // APB map
  localparam int unsigned ADDR_W      = 12;
  localparam logic [11:0] OFF_INSTR   = 12'h000;
  localparam logic [11:0] OFF_MADDR   = 12'h004;
  localparam logic [11:0] OFF_PC      = 12'h008;
  localparam logic [11:0] OFF_STATUS  = 12'h00c;
  localparam logic [11:0] OFF_CAFLAGS = 12'h010;
  localparam logic [11:0] OFF_DAFLAGS = 12'h014;
  localparam logic [11:0] OFF_OPA     = 12'h018;
  localparam logic [11:0] OFF_OPB     = 12'h01c;
  localparam logic [11:0] OFF_RESULT  = 12'h020;
  localparam logic [11:0] OFF_LOOP    = 12'h024;
  localparam logic [11:0] OFF_REGS    = 12'h080;
  localparam logic [4:0]  NUM_REGS    = 5'h16;

  // Instruction word fields and adder control bits of the operand B write
  localparam int unsigned OP_LSB     = 28;
  localparam int unsigned MODE_LSB   = 26;
  localparam int unsigned TGT_LSB    = 21;
  localparam int unsigned SEL_LSB    = 16;
  localparam int unsigned REGCNT_BIT = 15;
  localparam int unsigned SUB_BIT    = 24;
  localparam int unsigned EXT_BIT    = 25;

  // Loop limits
  localparam logic [4:0]  J_MAX = 5'h1f;
  localparam logic [10:0] K_MAX = 11'h7ff;

  // Flag nibble layout: n z v c (control unit), N Z V U (data unit)
  localparam int unsigned FLAG_N = 3;
  localparam int unsigned FLAG_Z = 2;
  localparam int unsigned FLAG_V = 1;
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_U = 0;

  // Status bits
  localparam int unsigned ST_TAKEN     = 0;
  localparam int unsigned ST_LOOP      = 1;
  localparam int unsigned ST_INT_OK    = 2;
  localparam int unsigned ST_IN_SERV   = 3;
  localparam int unsigned ST_DO_IN_ISR = 4;
  localparam int unsigned ST_BR_IN_DO  = 5;

  // Reset value and interrupt vector
  localparam logic [23:0] PC_RESET   = 24'h000000;
  localparam logic [23:0] INT_VECTOR = 24'h000100;

  typedef enum logic [3:0] {
    op_nop, op_goto, op_if_ca, op_if_reg, op_if_da, op_if_io,
    op_call, op_return, op_ireturn, op_do, op_plain
  } bclc_op_t;

  typedef enum logic [1:0] {tgt_reg, tgt_imm, tgt_reg_imm, tgt_addr} bclc_tgt_t;

  typedef enum logic [1:0] {cls_none, cls_ca, cls_da, cls_io} bclc_cls_t;

  typedef enum logic [4:0] {
    nonnegative_cond, negative_cond, nonzero_cond, zero_cond,
    ovf_clear, ovf_set, carry_clear, carry_set,
    signed_at_least, signed_below, signed_above, signed_at_most,
    unsigned_above, unsigned_at_most
  } bclc_ca_cond_t;

  typedef enum logic [4:0] {
    da_nonzero, da_zero, da_at_least_zero, da_below_zero,
    da_ovf_clear, da_ovf_set, da_unf_clear, da_unf_set,
    da_above_zero, da_at_most_zero
  } bclc_da_cond_t;

  typedef enum logic [4:0] {
    io_in_empty, io_in_full, io_out_empty, io_out_full,
    io_pd_empty, io_pd_full, io_pi_empty, io_pi_full,
    io_sync_low, io_sync_high, io_frame_clear, io_frame_set,
    io_req1_high, io_req1_low, io_req2_high, io_req2_low
  } bclc_io_cond_t;

  function automatic logic [23:0] sext16(input logic [15:0] v);
    sext16 = {{8{v[15]}}, v};
  endfunction : sext16

endpackage : bclc_pkg

// File: design/bclc_cond_if.sv
// Flags, pin levels and condition select passed to the condition evaluator
`timescale 1ns/1ps
`default_nettype none
interface bclc_cond_if;
  import bclc_pkg::*;
  logic [3:0] ca_flags;
  logic [3:0] da_flags;
  logic [7:0] io_pins;
  bclc_cls_t  cond_class;
  logic [4:0] cond_code;
  logic       cond_true;

  modport source (output ca_flags, da_flags, io_pins, cond_class, cond_code, input cond_true);
  modport judge  (input ca_flags, da_flags, io_pins, cond_class, cond_code, output cond_true);
endinterface : bclc_cond_if
`default_nettype wire

// File: design/bclc_cond_eval.sv
// Branch condition evaluator for control-unit, data-unit and I/O conditions
`timescale 1ns/1ps
`default_nettype none
module bclc_cond_eval (
  bclc_cond_if.judge cif
);
  import bclc_pkg::*;

  logic n, z, v, c, dn, dz, dv, du;
  logic [7:0] p;

  always_comb begin
    n  = cif.ca_flags[FLAG_N];
    z  = cif.ca_flags[FLAG_Z];
    v  = cif.ca_flags[FLAG_V];
    c  = cif.ca_flags[FLAG_C];
    dn = cif.da_flags[FLAG_N];
    dz = cif.da_flags[FLAG_Z];
    dv = cif.da_flags[FLAG_V];
    du = cif.da_flags[FLAG_U];
    p  = cif.io_pins;
    cif.cond_true = 1'b0;
    if (cif.cond_class == cls_ca) begin
      case (cif.cond_code)
        nonnegative_cond: cif.cond_true = ~n;
        negative_cond:    cif.cond_true = n;
        nonzero_cond:     cif.cond_true = ~z;
        zero_cond:        cif.cond_true = z;
        ovf_clear:        cif.cond_true = ~v;
        ovf_set:          cif.cond_true = v;
        carry_clear:      cif.cond_true = ~c;
        carry_set:        cif.cond_true = c;
        signed_at_least:  cif.cond_true = ~(n ^ v);
        signed_below:     cif.cond_true = n ^ v;
        signed_above:     cif.cond_true = ~(z | (n ^ v));
        signed_at_most:   cif.cond_true = z | (n ^ v);
        unsigned_above:   cif.cond_true = ~(c | z);
        unsigned_at_most: cif.cond_true = c | z;
        default:          cif.cond_true = 1'b0;
      endcase
    end else if (cif.cond_class == cls_da) begin
      case (cif.cond_code)
        da_nonzero:       cif.cond_true = ~dz;
        da_zero:          cif.cond_true = dz;
        da_at_least_zero: cif.cond_true = ~dn;
        da_below_zero:    cif.cond_true = dn;
        da_ovf_clear:     cif.cond_true = ~dv;
        da_ovf_set:       cif.cond_true = dv;
        da_unf_clear:     cif.cond_true = ~du;
        da_unf_set:       cif.cond_true = du;
        da_above_zero:    cif.cond_true = ~(dn | dz);
        da_at_most_zero:  cif.cond_true = dn | dz;
        default:          cif.cond_true = 1'b0;
      endcase
    end else if (cif.cond_class == cls_io) begin
      case (cif.cond_code)
        io_in_empty:    cif.cond_true = ~p[0];
        io_in_full:     cif.cond_true = p[0];
        io_out_empty:   cif.cond_true = p[1];
        io_out_full:    cif.cond_true = ~p[1];
        io_pd_empty:    cif.cond_true = ~p[2];
        io_pd_full:     cif.cond_true = p[2];
        io_pi_empty:    cif.cond_true = ~p[3];
        io_pi_full:     cif.cond_true = p[3];
        io_sync_low:    cif.cond_true = ~p[4];
        io_sync_high:   cif.cond_true = p[4];
        io_frame_clear: cif.cond_true = ~p[5];
        io_frame_set:   cif.cond_true = p[5];
        io_req1_high:   cif.cond_true = p[6];
        io_req1_low:    cif.cond_true = ~p[6];
        io_req2_high:   cif.cond_true = p[7];
        io_req2_low:    cif.cond_true = ~p[7];
        default:        cif.cond_true = 1'b0;
      endcase
    end
  end

endmodule : bclc_cond_eval
`default_nettype wire

// File: design/bclc_top.sv
// Branch, call, return and repeat-loop control with APB register access
// How it works
// - Repeat loop runs J+1 instructions count+1 times
// - Interrupts held until last body, last pass
// - Conditional branch to selected target, flags untouched
// - Register-test branch taken when register nonnegative
// - Call saves link, return and interrupt-return resume
// - Unconditional branch always jumps; nop only steps to the next instruction
// - Plus and minus test negative flag
// - Not-equal and equal test zero flag
// - Overflow and carry flags tested directly
// - Signed at-least/below use n xor v
// - Signed above/at-most use z or (n xor v)
// - Unsigned above/at-most use c or z
// - Data-unit zero and negative conditions
// - Data-unit overflow and underflow conditions
// - Data-unit above/at-most zero use N or Z
// - Parallel data full flag gives empty/full
// - Parallel interrupt full flag gives empty/full
// - Serial, sync and frame conditions
// - Request pins low means asserted
// - Carry from bit 15 or 23, n bit 23
// - Request pin flags read one when high
`timescale 1ns/1ps
`default_nettype none
module bclc_top (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [bclc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output var  logic [31:0]                prdata,
  output var  logic                       pready,
  output var  logic                       pslverr,
  input  wire logic                       in_buf_full,
  input  wire logic                       out_buf_empty,
  input  wire logic                       pdata_full,
  input  wire logic                       pint_full,
  input  wire logic                       handshake_line,
  input  wire logic                       frame_edge_flag,
  input  wire logic                       ext_request_one,
  input  wire logic                       ext_request_two,
  input  wire logic                       int_request,
  output var  logic                       int_ack,
  output var  logic                       int_allowed,
  output var  logic                       in_service,
  output var  logic                       branch_taken
);
  import bclc_pkg::*;

  bclc_cond_if cif ();

  bclc_cond_eval u_eval (
    .cif (cif)
  );

  logic [23:0] pc;
  logic [23:0] maddr;
  logic [23:0] opa;
  logic [23:0] alu_result;
  logic [23:0] regs [1:22];
  logic [3:0]  ca_flags;
  logic [3:0]  da_flags;
  logic [31:0] last_instr;
  logic        loop_active;
  logic [23:0] loop_start;
  logic [23:0] loop_end;
  logic [10:0] iter_left;
  logic [23:0] int_ret_pc;
  logic        do_in_isr_err;
  logic        br_in_do_err;

  logic        wr_en;
  logic        setup;
  logic        issue;
  bclc_op_t    op;
  bclc_tgt_t   mode;
  logic [4:0]  tgt_idx;
  logic [4:0]  sel;
  logic [23:0] target;
  logic [23:0] sel_val;
  logic        take;
  logic        at_loop_end;
  logic        loop_repeat;
  logic [31:0] rd_value;
  logic        rd_hit;
  logic        take_int;
  logic        is_branch;

  // Register slot 1..22 for an address in the register window, else 0
  function automatic logic [4:0] reg_slot(input logic [11:0] a);
    logic [11:0] d;
    d = a - OFF_REGS;
    reg_slot = 5'h00;
    if (a >= OFF_REGS && d[1:0] == 2'b00 && d[11:2] >= 10'h001 && d[11:2] <= {5'h00, NUM_REGS}) begin
      reg_slot = d[6:2];
    end
  endfunction : reg_slot

  // Index 0 reads the program counter
  function automatic logic [23:0] read_reg(input logic [4:0] idx);
    read_reg = 24'h000000;
    if (idx == 5'h00) begin
      read_reg = pc;
    end else if (idx <= NUM_REGS) begin
      read_reg = regs[idx];
    end
  endfunction : read_reg

  // Add or subtract in 16- or 24-bit width, returns {n,z,v,c,result}
  function automatic logic [27:0] alu_eval(input logic [23:0] a, input logic [23:0] b,
                                           input logic sub, input logic ext);
    logic [23:0] bb;
    logic [24:0] s;
    logic [16:0] lo;
    logic [23:0] res;
    logic        cout;
    logic        cin_msb;
    bb = sub ? ~b : b;
    s  = {1'b0, a} + {1'b0, bb} + {24'h000000, sub};
    lo = {1'b0, a[15:0]} + {1'b0, bb[15:0]} + {16'h0000, sub};
    if (ext) begin
      res     = s[23:0];
      cout    = s[24];
      cin_msb = a[23] ^ bb[23] ^ s[23];
    end else begin
      res     = sext16(lo[15:0]);
      cout    = lo[16];
      cin_msb = a[15] ^ bb[15] ^ lo[15];
    end
    // Borrow is the inverted carry on subtract
    alu_eval = {res[23], res == 24'h000000, cin_msb ^ cout, cout ^ sub, res};
  endfunction : alu_eval

  // APB handshake
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite;
  assign issue = wr_en && paddr == OFF_INSTR;

  always_comb begin
    op     = bclc_op_t'(pwdata[OP_LSB +: 4]);
    mode   = bclc_tgt_t'(pwdata[MODE_LSB +: 2]);
    tgt_idx = pwdata[TGT_LSB +: 5];
    sel     = pwdata[SEL_LSB +: 5];
    sel_val = read_reg(sel);
  end

  always_comb begin
    cif.ca_flags   = ca_flags;
    cif.da_flags   = da_flags;
    cif.io_pins    = {ext_request_two, ext_request_one, frame_edge_flag, handshake_line,
                      pint_full, pdata_full, out_buf_empty, in_buf_full};
    cif.cond_code  = sel;
    cif.cond_class = cls_none;
    if (op == op_if_ca) begin
      cif.cond_class = cls_ca;
    end else if (op == op_if_da) begin
      cif.cond_class = cls_da;
    end else if (op == op_if_io) begin
      cif.cond_class = cls_io;
    end
  end

  // Target select and branch decision
  always_comb begin
    unique case (mode)
      tgt_reg:     target = read_reg(tgt_idx);
      tgt_imm:     target = sext16(pwdata[15:0]);
      tgt_reg_imm: target = read_reg(tgt_idx) + sext16(pwdata[15:0]);
      tgt_addr:    target = maddr;
    endcase
    take = 1'b0;
    case (op)
      op_goto:    take = 1'b1;
      op_if_ca,
      op_if_da,
      op_if_io:   take = cif.cond_true;
      op_if_reg:  take = ~sel_val[23];
      op_call:    take = 1'b1;
      op_return: begin
        take   = 1'b1;
        target = sel_val;
      end
      op_ireturn: begin
        take   = 1'b1;
        target = int_ret_pc;
      end
      default:    take = 1'b0;
    endcase
    is_branch = op == op_goto || op == op_call || op == op_if_ca || op == op_if_da ||
                op == op_if_io || op == op_if_reg;
  end

  assign at_loop_end = loop_active && pc == loop_end;
  assign loop_repeat = at_loop_end && iter_left != 11'h000;
  assign take_int    = !issue && int_request && int_allowed && !in_service;

  // Sequencer: program counter, loop and interrupt gating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc           <= PC_RESET;
      loop_active  <= 1'b0;
      loop_start   <= 24'h000000;
      loop_end     <= 24'h000000;
      iter_left    <= 11'h000;
      int_allowed  <= 1'b1;
      in_service   <= 1'b0;
      int_ret_pc   <= 24'h000000;
      int_ack      <= 1'b0;
      branch_taken <= 1'b0;
    end else begin
      int_ack      <= 1'b0;
      branch_taken <= 1'b0;
      if (issue) begin
        if (op == op_do) begin
          loop_active <= 1'b1;
          loop_start  <= pc + 24'h000001;
          loop_end    <= pc + 24'h000001 + {19'h00000, sel & J_MAX};
          iter_left   <= pwdata[REGCNT_BIT] ? (11'(read_reg(tgt_idx)) & K_MAX) : (pwdata[10:0] & K_MAX);
          pc          <= pc + 24'h000001;
          int_allowed <= 1'b0;
        end else begin
          // open only after final body, final pass
          int_allowed <= !(loop_active && !(at_loop_end && iter_left == 11'h000));
          if (take) begin
            pc           <= target;
            branch_taken <= 1'b1;
          end else if (loop_repeat) begin
            pc        <= loop_start;
            iter_left <= iter_left - 11'h001;
          end else begin
            pc <= pc + 24'h000001;
          end
          if (at_loop_end && !loop_repeat) begin
            loop_active <= 1'b0;
          end
          if (op == op_ireturn) begin
            in_service <= 1'b0;
          end
        end
      end else if (take_int) begin
        int_ret_pc <= pc;
        pc         <= INT_VECTOR;
        in_service <= 1'b1;
        int_ack    <= 1'b1;
      end else if (wr_en && paddr == OFF_PC) begin
        pc <= pwdata[23:0];
      end
    end
  end

  // Register file: software writes and call link
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 1; i <= 22; i++) begin
        regs[i] <= 24'h000000;
      end
    end else begin
      if (wr_en && reg_slot(paddr) != 5'h00) begin
        regs[reg_slot(paddr)] <= pwdata[23:0];
      end
      if (issue && op == op_call && sel != 5'h00 && sel <= NUM_REGS) begin
        regs[sel] <= pc + 24'h000001;
      end
    end
  end

  // Flags: branches leave them alone, only software and the adder move them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ca_flags   <= 4'h0;
      da_flags   <= 4'h0;
      opa        <= 24'h000000;
      alu_result <= 24'h000000;
    end else begin
      if (wr_en && paddr == OFF_CAFLAGS) begin
        ca_flags <= pwdata[3:0];
      end
      if (wr_en && paddr == OFF_DAFLAGS) begin
        da_flags <= pwdata[3:0];
      end
      if (wr_en && paddr == OFF_OPA) begin
        opa <= pwdata[23:0];
      end
      // carry from bit 15 or 23
      if (wr_en && paddr == OFF_OPB) begin
        {ca_flags, alu_result} <= alu_eval(opa, pwdata[23:0], pwdata[SUB_BIT], pwdata[EXT_BIT]);
      end
    end
  end

  // Misc registers and sticky misuse flags; a new event beats a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      maddr         <= 24'h000000;
      last_instr    <= 32'h00000000;
      do_in_isr_err <= 1'b0;
      br_in_do_err  <= 1'b0;
    end else begin
      if (wr_en && paddr == OFF_MADDR) begin
        maddr <= pwdata[23:0];
      end
      if (issue) begin
        last_instr <= pwdata;
      end
      if (issue && op == op_do && in_service) begin
        do_in_isr_err <= 1'b1;
      end else if (wr_en && paddr == OFF_STATUS && pwdata[ST_DO_IN_ISR]) begin
        do_in_isr_err <= 1'b0;
      end
      // branch in body flagged, outcome undefined
      if (issue && is_branch && loop_active) begin
        br_in_do_err <= 1'b1;
      end else if (wr_en && paddr == OFF_STATUS && pwdata[ST_BR_IN_DO]) begin
        br_in_do_err <= 1'b0;
      end
    end
  end

  // Read mux
  always_comb begin
    rd_value = 32'h00000000;
    rd_hit   = 1'b1;
    if (reg_slot(paddr) != 5'h00) begin
      rd_value = {8'h00, read_reg(reg_slot(paddr))};
    end else begin
      case (paddr)
        OFF_INSTR:   rd_value = last_instr;
        OFF_MADDR:   rd_value = {8'h00, maddr};
        OFF_PC:      rd_value = {8'h00, pc};
        OFF_STATUS: begin
          rd_value[ST_TAKEN]     = branch_taken;
          rd_value[ST_LOOP]      = loop_active;
          rd_value[ST_INT_OK]    = int_allowed;
          rd_value[ST_IN_SERV]   = in_service;
          rd_value[ST_DO_IN_ISR] = do_in_isr_err;
          rd_value[ST_BR_IN_DO]  = br_in_do_err;
        end
        OFF_CAFLAGS: rd_value = {28'h0000000, ca_flags};
        OFF_DAFLAGS: rd_value = {28'h0000000, da_flags};
        OFF_OPA:     rd_value = {8'h00, opa};
        OFF_OPB:     rd_value = 32'h00000000;
        OFF_RESULT:  rd_value = {8'h00, alu_result};
        OFF_LOOP:    rd_value = {5'h00, iter_left, 15'h0000, loop_active};
        default:     rd_hit   = 1'b0;
      endcase
    end
  end

  // APB answer: zero wait, data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata  <= pwrite ? 32'h00000000 : rd_value;
        pslverr <= !rd_hit;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

endmodule : bclc_top
`default_nettype wire

// File: bench/bclc_top_assertions.sv
// Port-level checks of branch, loop and interrupt control
`timescale 1ns/1ps
`default_nettype none
module bclc_top_assertions (
  input wire logic                         pclk,
  input wire logic                         presetn,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [bclc_pkg::ADDR_W-1:0]  paddr,
  input wire logic [31:0]                  pwdata,
  input wire logic                         pready,
  input wire logic                         out_buf_empty,
  input wire logic                         pdata_full,
  input wire logic                         pint_full,
  input wire logic                         ext_request_one,
  input wire logic                         int_request,
  input wire logic                         int_ack,
  input wire logic                         int_allowed,
  input wire logic                         in_service,
  input wire logic                         branch_taken
);
  import bclc_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Accepted instruction word of one class
  sequence s_iss(logic [3:0] op);
    psel && penable && pready && pwrite && paddr == OFF_INSTR && pwdata[31:28] == op;
  endsequence
  sequence s_io(logic [4:0] code);
    s_iss(4'h5) ##0 pwdata[20:16] == code;
  endsequence
  property p_req1; s_io(5'h0d) |=> branch_taken == !$past(ext_request_one); endproperty
  a_req1: assert property (p_req1) else $error("request pin branch wrong");
  property p_obe; s_io(5'h02) |=> branch_taken == $past(out_buf_empty); endproperty
  a_obe: assert property (p_obe) else $error("output empty branch wrong");
  property p_pdf; s_io(5'h05) |=> branch_taken == $past(pdata_full); endproperty
  a_pdf: assert property (p_pdf) else $error("parallel data branch wrong");
  property p_pie; s_io(5'h06) |=> branch_taken == !$past(pint_full); endproperty
  a_pie: assert property (p_pie) else $error("parallel interrupt branch wrong");
  property p_goto; s_iss(4'h1) |=> branch_taken; endproperty
  a_goto: assert property (p_goto) else $error("goto not taken");
  property p_nop; s_iss(4'h0) |=> !branch_taken && !int_ack; endproperty
  a_nop: assert property (p_nop) else $error("nop had an effect");
  property p_do_mask; s_iss(4'h9) |=> !int_allowed; endproperty
  a_do_mask: assert property (p_do_mask) else $error("loop start left interrupts open");
  // Acceptance only when open, idle and no issue
  property p_ack_cause;
    int_ack |-> $past(int_allowed && int_request && !in_service && !(psel && penable && pwrite && paddr == OFF_INSTR));
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("interrupt taken while held");
  property p_ack_serv; int_ack |-> in_service ##1 !int_ack; endproperty
  a_ack_serv: assert property (p_ack_serv) else $error("acceptance pulse wrong");
  property p_bt_pulse; branch_taken |=> !branch_taken; endproperty
  a_bt_pulse: assert property (p_bt_pulse) else $error("branch pulse too long");
endmodule : bclc_top_assertions
bind bclc_top bclc_top_assertions u_chk (.*);
`default_nettype wire

// File: bench/branch_condition_and_loop_control_tb.sv
// Self-checking bench for branch, loop and interrupt control
`timescale 1ns/1ps
`default_nettype none
module branch_condition_and_loop_control_tb;
  import bclc_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, int_request = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, int_ack, int_allowed, in_service, branch_taken, bt, err;
  logic [7:0]  pins = '0;
  int          miscompares = 0, total_checks = 0;
  // Rows: op, condition code, flags or pin byte, expected jump
  logic [19:0] rows [27] = '{20'h2c001, 20'h2c010, 20'h2a0a1, 20'h2b081, 20'h28080, 20'h20001,
    20'h23041, 20'h27011, 20'h25000, 20'h2d041, 20'h48001, 20'h49041, 20'h47011, 20'h43081,
    20'h5d001, 20'h5d400, 20'h52021, 20'h55000, 20'h55041, 20'h56001, 20'h5e801, 20'h59101,
    20'h5b000, 20'h50010, 20'h53001, 20'h10001, 20'h00000};
  bclc_top uut (.*, .in_buf_full(pins[0]), .out_buf_empty(pins[1]), .pdata_full(pins[2]),
    .pint_full(pins[3]), .handshake_line(pins[4]), .frame_edge_flag(pins[5]),
    .ext_request_one(pins[6]), .ext_request_two(pins[7]));
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  task end_sim;
    if (miscompares == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Entered just after a rising edge; leaves one edge after the transfer
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      miscompares++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
    bt = branch_taken;
    @(posedge pclk);
  endtask : apb
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rchk
  initial begin
    int n;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(int_allowed, 1'b1);
    rchk(OFF_PC, 32'h0);
    foreach (rows[i]) begin
      pins <= rows[i][11:4];
      apb(1'b1, OFF_CAFLAGS, {28'h0, rows[i][7:4]});
      apb(1'b1, OFF_DAFLAGS, {28'h0, rows[i][7:4]});
      apb(1'b1, OFF_PC, 32'h0);
      apb(1'b1, OFF_INSTR, {rows[i][19:16], 2'b01, 5'h00, 1'b0, rows[i][15:12], 16'h0040});
      chk(bt, rows[i][0]);
      rchk(OFF_PC, rows[i][0] ? 32'h40 : 32'h1);
    end
    apb(1'b1, OFF_PC, 32'h5);
    apb(1'b1, OFF_INSTR, {4'h6, 2'b01, 5'h00, 5'h03, 16'h0020});
    rchk(OFF_PC, 32'h20);
    rchk(OFF_REGS + 12'h00c, 32'h6);
    apb(1'b1, OFF_INSTR, {4'h3, 2'b01, 5'h00, 5'h03, 16'h0040});
    chk(bt, 1'b1);
    apb(1'b1, OFF_INSTR, {4'h7, 2'b00, 5'h00, 5'h03, 16'h0000});
    rchk(OFF_PC, 32'h6);
    apb(1'b1, OFF_REGS + 12'h00c, 32'h800000);
    apb(1'b1, OFF_INSTR, {4'h3, 2'b01, 5'h00, 5'h03, 16'h0040});
    chk(bt, 1'b0);
    // Carry out of bit 15, then signed overflow at bit 23
    apb(1'b1, OFF_OPA, 32'h00ffff);
    apb(1'b1, OFF_OPB, 32'h000001);
    rchk(OFF_CAFLAGS, 32'h5);
    apb(1'b1, OFF_OPA, 32'h7fffff);
    apb(1'b1, OFF_OPB, 32'h2000001);
    rchk(OFF_CAFLAGS, 32'ha);
    apb(1'b0, 12'h040, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    // Untaken branch must leave the adder flags alone
    apb(1'b1, OFF_INSTR, {4'h2, 2'b01, 5'h00, 5'h03, 16'h0040});
    chk(bt, 1'b0);
    rchk(OFF_CAFLAGS, 32'ha);
    // Two instructions run twice, interrupts held until the last one
    apb(1'b1, OFF_PC, 32'h0);
    apb(1'b1, OFF_INSTR, {4'h9, 2'b01, 5'h00, 5'h01, 16'h0001});
    chk(int_allowed, 1'b0);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, OFF_INSTR, {4'ha, 28'h0});
      chk(int_allowed, k == 3);
      rchk(OFF_PC, (k == 1) ? 32'h1 : (k == 3) ? 32'h3 : 32'h2);
    end
    int_request <= 1'b1;
    n = 0;
    while (int_ack !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    int_request <= 1'b0;
    if (n >= 20) begin
      miscompares++;
      end_sim();
    end
    chk(in_service, 1'b1);
    rchk(OFF_PC, {8'h0, INT_VECTOR});
    apb(1'b1, OFF_INSTR, {4'h8, 28'h0});
    chk(in_service, 1'b0);
    rchk(OFF_PC, 32'h3);
    rchk(OFF_STATUS, 32'h4);
    // Reset in mid-run returns outputs to idle
    presetn <= 1'b0;
    @(posedge pclk);
    chk({pready, int_ack, int_allowed, in_service, branch_taken}, 5'h04);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(OFF_PC, 32'h0);
    end_sim();
  end
endmodule : branch_condition_and_loop_control_tb
`default_nettype wire
